// ==== verilog/swd_regs.vh ====
// Notes on behaviour
// - a liveness check command is answered with an acknowledge.
// - acknowledge is coded as one response value and negative ack as the next.
// - the identification command returns the device identification code.
// - the status command returns a status message.
// - the baud query returns the baud rate currently used on the link.
// - the speed query returns the ratio of link clock to system bus clock.
// - the erase command erases the flash and all volatile memories.
// - the two-pin command enables the separate output pin and two-pin mode.
// - in two-pin mode every response leaves on the dedicated output pin.
// - the bus-write command writes word, halfword or byte to the system bus.
// - the bus-read command reads word, halfword or byte and returns data.
// - the halt command raises a halt request to the processor.
// - the reset command forwards a reset request to the reset controller.
// - the guard-time command updates the guard time from the supplied data.
// - every packet carries its code in a command or response field.
// - a data field is optional and absent for commands without data.
`ifndef SWD_REGS_VH
`define SWD_REGS_VH
// ==========================================================
// command codes
`define SWD_CMD_ALIVE 8'h01
`define SWD_CMD_IDENT 8'h02
`define SWD_CMD_STATUS 8'h03
`define SWD_CMD_BAUD 8'h04
`define SWD_CMD_SPEED 8'h05
`define SWD_CMD_ERASE 8'h06
`define SWD_CMD_DISABLE 8'h07
`define SWD_CMD_TWOPIN 8'h08
`define SWD_CMD_WRITE 8'h80
`define SWD_CMD_READ 8'h81
`define SWD_CMD_HALT 8'h82
`define SWD_CMD_RESET 8'h83
`define SWD_CMD_GUARD 8'h84
// ==========================================================
// response codes
`define SWD_RSP_ACK 8'h40
`define SWD_RSP_NACK 8'h41
// ==========================================================
// size field of bus access (low bits of first data byte)
`define SWD_SIZE_BYTE 2'h0
`define SWD_SIZE_HALF 2'h1
`define SWD_SIZE_WORD 2'h2
// ==========================================================
// reset values and timing
`define SWD_GUARD_RESET 8'h00
`define SWD_BUS_TIMEOUT_NS 640
`define SWD_CLK_NS 5
`endif

// ==== verilog/swd_bus_access.v ====
`timescale 1ns/1ps
`include "swd_regs.vh"
// ==========================================================
// system bus access engine: one transfer, with a timeout
module swd_bus_access #(
  parameter integer TIMEOUT_CYC = `SWD_BUS_TIMEOUT_NS / `SWD_CLK_NS
) (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // request
  input wire start,
  input wire write,
  input wire [1:0] size,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  output reg done,
  output reg error,
  output reg [31:0] rdata,
  // system bus
  output reg sys_bus_req,
  output reg sys_bus_we,
  output reg [1:0] sys_bus_size,
  output reg [31:0] sys_bus_addr,
  output reg [31:0] sys_bus_wdata,
  input wire sys_bus_ack,
  input wire sys_bus_err,
  input wire [31:0] sys_bus_rdata
);
  reg [15:0] tmo_reg;
  // a stuck bus ends in an error so the link never hangs
  always @(posedge clock) begin
    if (!rst_b) begin
      done <= 1'b0;
      error <= 1'b0;
      rdata <= 32'h0;
      sys_bus_req <= 1'b0;
      sys_bus_we <= 1'b0;
      sys_bus_size <= 2'h0;
      sys_bus_addr <= 32'h0;
      sys_bus_wdata <= 32'h0;
      tmo_reg <= 16'h0;
    end else begin
      done <= 1'b0;
      if (start && !sys_bus_req) begin
        sys_bus_req <= 1'b1;
        sys_bus_we <= write;
        sys_bus_size <= size;
        sys_bus_addr <= addr;
        sys_bus_wdata <= wdata;
        tmo_reg <= 16'h0;
      end else if (sys_bus_req) begin
        tmo_reg <= tmo_reg + 16'h1;
        if (sys_bus_ack || sys_bus_err || tmo_reg == TIMEOUT_CYC[15:0]) begin
          sys_bus_req <= 1'b0;
          done <= 1'b1;
          error <= !sys_bus_ack;
          rdata <= sys_bus_rdata;
        end
      end
    end
  end
endmodule // swd_bus_access

// ==== verilog/swd_cmd_decoder.v ====
`timescale 1ns/1ps
`include "swd_regs.vh"
// ==========================================================
// command decoder of the single-wire debug link unit.
// packets arrive as bytes: code byte, then the data bytes the code needs.
// response bytes leave one per cycle as a stream, code byte first.
module swd_cmd_decoder #(
  parameter [31:0] IDCODE = 32'h0000_0001, // arbitrary value
  parameter [15:0] BAUD_DEFAULT = 16'h0100,
  parameter [7:0] SPEED_RATIO = 8'h01,
  parameter [7:0] STATUS_BITS = 8'h00
) (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // received bytes from the framing layer
  input wire rx_valid,
  input wire rx_first,
  input wire [7:0] rx_byte,
  input wire [15:0] baud_current,
  // response stream
  output reg tx_valid,
  output reg tx_last,
  output reg [7:0] tx_byte,
  output reg tx_on_pin,
  output reg tx_on_line,
  // pins and modes
  output reg two_pin_mode,
  output reg link_enable,
  output reg [7:0] guard_time,
  // chip control
  output reg erase_req,
  output reg halt_req,
  output reg reset_req,
  // system bus
  output wire sys_bus_req,
  output wire sys_bus_we,
  output wire [1:0] sys_bus_size,
  output wire [31:0] sys_bus_addr,
  output wire [31:0] sys_bus_wdata,
  input wire sys_bus_ack,
  input wire sys_bus_err,
  input wire [31:0] sys_bus_rdata
);
  // ==========================================================
  // states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DATA = 3'h1;
  localparam [2:0] ST_EXEC = 3'h2;
  localparam [2:0] ST_BUS = 3'h3;
  localparam [2:0] ST_SEND = 3'h4;

  // data bytes that each command carries
  function [3:0] data_len;
    input [7:0] code;
    begin
      case (code)
        `SWD_CMD_WRITE: data_len = 4'h9; // size, address, data
        `SWD_CMD_READ: data_len = 4'h5; // size, address
        `SWD_CMD_GUARD: data_len = 4'h1;
        default: data_len = 4'h0;
      endcase
    end
  endfunction

  // known command codes
  function known;
    input [7:0] code;
    begin
      case (code)
        `SWD_CMD_ALIVE, `SWD_CMD_IDENT, `SWD_CMD_STATUS, `SWD_CMD_BAUD,
        `SWD_CMD_SPEED, `SWD_CMD_ERASE, `SWD_CMD_DISABLE,
        `SWD_CMD_TWOPIN, `SWD_CMD_WRITE, `SWD_CMD_READ, `SWD_CMD_HALT,
        `SWD_CMD_RESET, `SWD_CMD_GUARD: known = 1'b1;
        default: known = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // state
  reg [2:0] state_reg;
  reg [7:0] cmd_reg;
  reg [3:0] need_reg;
  reg [3:0] got_reg;
  reg [71:0] data_reg;
  reg [39:0] rsp_reg;
  reg [2:0] rsp_len_reg;
  reg [2:0] rsp_idx_reg;
  reg bus_start_reg;
  wire bus_done;
  wire bus_error;
  wire [31:0] bus_rdata;

  // ==========================================================
  // bus engine
  swd_bus_access swd_bus_access_inst (
    .clock(clock),
    .rst_b(rst_b),
    .start(bus_start_reg),
    .write(cmd_reg == `SWD_CMD_WRITE),
    .size(data_reg[1:0]),
    .addr(data_reg[39:8]),
    .wdata(data_reg[71:40]),
    .done(bus_done),
    .error(bus_error),
    .rdata(bus_rdata),
    .sys_bus_req(sys_bus_req),
    .sys_bus_we(sys_bus_we),
    .sys_bus_size(sys_bus_size),
    .sys_bus_addr(sys_bus_addr),
    .sys_bus_wdata(sys_bus_wdata),
    .sys_bus_ack(sys_bus_ack),
    .sys_bus_err(sys_bus_err),
    .sys_bus_rdata(sys_bus_rdata)
  );

  // ==========================================================
  // receive, execute and answer; one command at a time, the host
  // waits for each answer, so bytes arriving mid-answer are dropped
  always @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      need_reg <= 4'h0;
      got_reg <= 4'h0;
      data_reg <= 72'h0;
      rsp_reg <= 40'h0;
      rsp_len_reg <= 3'h0;
      rsp_idx_reg <= 3'h0;
      bus_start_reg <= 1'b0;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_byte <= 8'h00;
      tx_on_pin <= 1'b0;
      tx_on_line <= 1'b0;
      two_pin_mode <= 1'b0;
      link_enable <= 1'b1;
      guard_time <= `SWD_GUARD_RESET;
      erase_req <= 1'b0;
      halt_req <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      bus_start_reg <= 1'b0;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_on_pin <= 1'b0;
      tx_on_line <= 1'b0;
      erase_req <= 1'b0;
      reset_req <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // the code byte opens every packet
          if (rx_valid && rx_first && link_enable) begin
            cmd_reg <= rx_byte;
            need_reg <= data_len(rx_byte);
            got_reg <= 4'h0;
            data_reg <= 72'h0;
            if (data_len(rx_byte) == 4'h0)
              state_reg <= ST_EXEC;
            else
              state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          // data bytes fill little-endian; a new code byte aborts to idle and is dropped
          if (rx_valid && rx_first) begin
            state_reg <= ST_IDLE;
          end else if (rx_valid) begin
            // placed by position so every command finds its first field at bit 0
            data_reg[8*got_reg +: 8] <= rx_byte;
            got_reg <= got_reg + 4'h1;
            if (got_reg + 4'h1 == need_reg)
              state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          rsp_reg <= {32'h0, `SWD_RSP_ACK};
          rsp_len_reg <= 3'h1;
          rsp_idx_reg <= 3'h0;
          state_reg <= ST_SEND;
          case (cmd_reg)
            `SWD_CMD_IDENT: begin
              rsp_reg <= {IDCODE, `SWD_RSP_ACK};
              rsp_len_reg <= 3'h5;
            end
            `SWD_CMD_STATUS: begin
              rsp_reg <= {24'h0, STATUS_BITS | {5'h0, halt_req,
                two_pin_mode, 1'b1}, `SWD_RSP_ACK};
              rsp_len_reg <= 3'h2;
            end
            `SWD_CMD_BAUD: begin
              rsp_reg <= {16'h0, baud_current, `SWD_RSP_ACK};
              rsp_len_reg <= 3'h3;
            end
            `SWD_CMD_SPEED: begin
              rsp_reg <= {24'h0, SPEED_RATIO, `SWD_RSP_ACK};
              rsp_len_reg <= 3'h2;
            end
            `SWD_CMD_ERASE: erase_req <= 1'b1;
            `SWD_CMD_DISABLE: link_enable <= 1'b0;
            `SWD_CMD_TWOPIN: two_pin_mode <= 1'b1;
            `SWD_CMD_WRITE, `SWD_CMD_READ: begin
              bus_start_reg <= 1'b1;
              state_reg <= ST_BUS;
            end
            `SWD_CMD_HALT: halt_req <= 1'b1;
            `SWD_CMD_RESET: reset_req <= 1'b1;
            `SWD_CMD_GUARD: guard_time <= data_reg[7:0];
            default: begin
              if (!known(cmd_reg))
                rsp_reg <= {32'h0, `SWD_RSP_NACK};
            end
          endcase
        end
        ST_BUS: begin
          if (bus_done) begin
            state_reg <= ST_SEND;
            if (bus_error) begin
              rsp_reg <= {32'h0, `SWD_RSP_NACK};
              rsp_len_reg <= 3'h1;
            end else if (cmd_reg == `SWD_CMD_READ) begin
              rsp_reg <= {bus_rdata, `SWD_RSP_ACK};
              rsp_len_reg <= 3'h5;
            end
          end
        end
        ST_SEND: begin
          // response code first, then data, low byte first
          tx_valid <= 1'b1;
          tx_byte <= rsp_reg[7:0];
          tx_on_pin <= two_pin_mode;
          tx_on_line <= !two_pin_mode;
          rsp_reg <= {8'h00, rsp_reg[39:8]};
          rsp_idx_reg <= rsp_idx_reg + 3'h1;
          if (rsp_idx_reg + 3'h1 == rsp_len_reg) begin
            tx_last <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // swd_cmd_decoder

// ==== verification/swd_bus_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// system bus slave: one word, adjustable wait, error on demand
module swd_bus_model (
  // clock and reset
  input logic clock,
  input logic rst_b,
  // bench control
  input logic [7:0] wait_cyc,
  input logic fail,
  // system bus
  input logic sys_bus_req,
  input logic sys_bus_we,
  input logic [1:0] sys_bus_size,
  input logic [31:0] sys_bus_addr,
  input logic [31:0] sys_bus_wdata,
  output logic sys_bus_ack,
  output logic sys_bus_err,
  output logic [31:0] sys_bus_rdata
);
  logic [31:0] mem_reg;
  logic [31:0] addr_reg;
  logic [1:0] size_reg;
  logic [7:0] cnt_reg;
  // data only holds with ack; the inverse elsewhere catches early sampling
  assign sys_bus_rdata = sys_bus_ack ? mem_reg : ~mem_reg;
  // wait, then one ack or error pulse; writes land on ack
  always @(posedge clock) begin
    sys_bus_ack <= 1'b0;
    sys_bus_err <= 1'b0;
    if (!rst_b || !sys_bus_req || sys_bus_ack || sys_bus_err) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == wait_cyc) begin
      sys_bus_ack <= !fail;
      sys_bus_err <= fail;
      size_reg <= sys_bus_size;
      addr_reg <= sys_bus_addr;
      if (sys_bus_we && !fail) mem_reg <= sys_bus_wdata;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule // swd_bus_model

// ==== verification/swd_chk_assertions.sv ====
`timescale 1ns/1ps
// ==========================================================
// port checks of the command decoder
module swd_chk #(
  parameter [31:0] IDCODE = 32'h0000_0001,
  parameter [7:0] SPEED_RATIO = 8'h01
) (
  // clock and reset
  input logic clock,
  input logic rst_b,
  // link side
  input logic rx_valid,
  input logic rx_first,
  input logic [7:0] rx_byte,
  input logic [15:0] baud_current,
  input logic tx_valid,
  input logic tx_last,
  input logic [7:0] tx_byte,
  input logic tx_on_pin,
  input logic tx_on_line,
  // modes and requests
  input logic two_pin_mode,
  input logic link_enable,
  input logic erase_req,
  input logic halt_req,
  // system bus
  input logic sys_bus_req,
  input logic sys_bus_ack,
  input logic sys_bus_err
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // code byte taken while enabled; 0x00 is no command
  wire [7:0] code = (rx_valid && rx_first && link_enable) ? rx_byte : 8'h00;
  a_alive_ack: assert property (
    code == 8'h01 |-> ##3 tx_valid && tx_last && tx_byte == 8'h40)
    else $error("alive not acked");
  a_unknown_nack: assert property (
    code == 8'h10 |-> ##3 tx_valid && tx_last && tx_byte == 8'h41)
    else $error("unknown code not nacked");
  a_ident_bytes: assert property (
    code == 8'h02 |-> ##4 tx_byte == IDCODE[7:0] ##1 tx_byte == IDCODE[15:8]
    ##1 tx_byte == IDCODE[23:16] ##1 tx_byte == IDCODE[31:24] && tx_last)
    else $error("ident bytes wrong");
  a_baud_bytes: assert property (
    code == 8'h04 |-> ##4 tx_valid && tx_byte == baud_current[7:0]
    ##1 tx_byte == baud_current[15:8] && tx_last)
    else $error("baud bytes wrong");
  a_erase_pulse: assert property (
    code == 8'h06 |-> ##[1:3] erase_req ##1 !erase_req)
    else $error("erase pulse missing");
  a_twopin_set: assert property (
    code == 8'h08 |-> ##[1:3] two_pin_mode)
    else $error("two-pin mode not set");
  a_pin_select: assert property (
    tx_valid |-> tx_on_pin == two_pin_mode && tx_on_line == !two_pin_mode)
    else $error("response on wrong output");
  a_halt_sticky: assert property (
    halt_req |=> halt_req)
    else $error("halt request dropped");
  // ack edge, then done, then the send state launches the first byte
  a_bus_ack_ans: assert property (
    sys_bus_req && sys_bus_ack && !sys_bus_err |->
    ##3 tx_valid && tx_byte == 8'h40)
    else $error("bus ack not answered");
  a_bus_err_nack: assert property (
    sys_bus_req && sys_bus_err |->
    ##3 tx_valid && tx_last && tx_byte == 8'h41)
    else $error("bus error not nacked");
  c_bus_write: cover property (code == 8'h80);
  c_bus_error: cover property (sys_bus_req && sys_bus_err);
  c_pin_reply: cover property (tx_valid && tx_on_pin);
endmodule // swd_chk
bind swd_cmd_decoder swd_chk #(.IDCODE(IDCODE), .SPEED_RATIO(SPEED_RATIO))
  swd_chk_inst (.*);

// ==== verification/test_swd_cmd_decoder.sv ====
`timescale 1ns/1ps
module test_swd_cmd_decoder;
  localparam logic [31:0] ID = 32'hc0de_5a01; // arbitrary value
  localparam logic [7:0] SR = 8'h03;
  logic clock = 1'b0, rst_b = 1'b0, rx_valid = 1'b0, rx_first = 1'b0;
  logic [7:0] rx_byte = 8'h00, wait_cyc = 8'h00;
  logic [15:0] baud_current = 16'h1234;
  logic fail = 1'b0, on_pin, tx_valid, tx_last, tx_on_pin, tx_on_line;
  logic two_pin_mode, link_enable, erase_req, halt_req, reset_req, on_line;
  logic sys_bus_req, sys_bus_we, sys_bus_ack, sys_bus_err;
  logic [7:0] tx_byte, guard_time, rsp[$];
  logic [1:0] sys_bus_size;
  logic [31:0] sys_bus_addr, sys_bus_wdata, sys_bus_rdata;
  int fails = 0, checks_done = 0, cyc = 0, n_erase = 0, n_reset = 0;
  swd_cmd_decoder #(.IDCODE(ID), .SPEED_RATIO(SR)) swd_cmd_decoder_inst (.*);
  swd_bus_model swd_bus_model_inst (.*);
  // clock, pulse counters and hang guard
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    n_erase += (erase_req === 1'b1);
    n_reset += (reset_req === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset(input int n);
    @(negedge clock);
    rst_b = 1'b0;
    repeat (n) @(negedge clock);
    rst_b = 1'b1;
  endtask
  // code byte then data bytes lsb first, one per cycle
  task automatic send(input logic [7:0] c, input logic [71:0] d, input int n);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_first = 1'b1;
    rx_byte = c;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      rx_first = 1'b0;
      rx_byte = d[8*i +: 8];
    end
    @(negedge clock);
    rx_valid = 1'b0;
  endtask
  // gather the reply; the host waits for it before the next packet
  task automatic get(input int lim);
    rsp.delete();
    repeat (lim) begin
      @(negedge clock);
      if (tx_valid === 1'b1) begin
        rsp.push_back(tx_byte);
        on_pin = tx_on_pin;
        on_line = tx_on_line;
        if (tx_last === 1'b1) break;
      end
    end
  endtask
  task automatic xfer(input logic [7:0] c, input logic [71:0] d, input int nd,
    input logic [39:0] e, input int ne, input logic pin);
    send(c, d, nd);
    get(300);
    cmp(rsp.size(), ne);
    for (int i = 0; i < ne; i++) cmp(rsp[i], e[8*i +: 8]);
    cmp(on_pin, pin);
    cmp(on_line, !pin);
  endtask
  task automatic t_info;
    xfer(8'h01, 0, 0, 8'h40, 1, 0);
    xfer(8'h02, 0, 0, {ID, 8'h40}, 5, 0);
    xfer(8'h03, 0, 0, 16'h0140, 2, 0);
    xfer(8'h04, 0, 0, {16'h1234, 8'h40}, 3, 0);
    xfer(8'h05, 0, 0, {SR, 8'h40}, 2, 0);
    xfer(8'h10, 0, 0, 8'h41, 1, 0);
  endtask
  task automatic t_ctrl;
    xfer(8'h06, 0, 0, 8'h40, 1, 0);
    cmp(n_erase, 1);
    xfer(8'h83, 0, 0, 8'h40, 1, 0);
    cmp(n_reset, 1);
    xfer(8'h82, 0, 0, 8'h40, 1, 0);
    cmp(halt_req, 1);
    xfer(8'h84, 8'h5a, 1, 8'h40, 1, 0);
    cmp(guard_time, 8'h5a);
    xfer(8'h03, 0, 0, 16'h0540, 2, 0);
  endtask
  task automatic t_bus;
    for (int s = 0; s < 3; s++) begin
      xfer(8'h80, {32'ha5c3_0f00 + s, 32'h2000_0010, 8'(s)}, 9, 8'h40, 1,
        0);
      cmp(swd_bus_model_inst.size_reg, s);
      cmp(swd_bus_model_inst.addr_reg, 32'h2000_0010);
    end
    cmp(swd_bus_model_inst.mem_reg, 32'ha5c3_0f02);
    wait_cyc = 8'd40;
    xfer(8'h81, 40'h2000_0020_01, 5, 40'ha5c3_0f02_40, 5, 0);
    cmp(swd_bus_model_inst.size_reg, 1);
    cmp(swd_bus_model_inst.addr_reg, 32'h2000_0020);
    fail = 1'b1;
    xfer(8'h81, 40'h2000_0010_02, 5, 8'h41, 1, 0);
    fail = 1'b0;
    wait_cyc = 8'd200;
    xfer(8'h81, 40'h2000_0010_02, 5, 8'h41, 1, 0);
    wait_cyc = 8'd0;
  endtask
  task automatic t_pin;
    xfer(8'h08, 0, 0, 8'h40, 1, 1);
    xfer(8'h01, 0, 0, 8'h40, 1, 1);
    xfer(8'h03, 0, 0, 16'h0740, 2, 1);
  endtask
  task automatic t_off;
    xfer(8'h07, 0, 0, 8'h40, 1, 1);
    send(8'h01, 0, 0);
    get(20);
    cmp(rsp.size(), 0);
    cmp(link_enable, 0);
    do_reset(2);
    xfer(8'h01, 0, 0, 8'h40, 1, 0);
    cmp(link_enable, 1);
    cmp({two_pin_mode, halt_req, guard_time}, 10'h000);
  endtask
  // main sequence
  initial begin
    do_reset(10);
    t_info();
    t_ctrl();
    t_bus();
    t_pin();
    t_off();
    give_verdict();
  end
endmodule // test_swd_cmd_decoder
